// >>> rtl/timer_pkg.sv
// Purpose: Shared constants for the asynchronous timer compare-output block
// Assumes: 8-bit register port, one system clock, async clock pin sampled as data
// Notes: Offsets are word indices on the plain register port
//
// Functional notes
// RQ1 - Mode zero leaves compare output state unchanged on a match
// RQ2 - A new mode value acts from the first match after the write
// RQ3 - Force strobe applies the mode action at once in non-PWM modes
// RQ4 - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// RQ5 - PWM mode 01 toggles channel A only with top mode bit; else off
// RQ6 - Fast PWM 10: clear on match, set at BOTTOM
// RQ7 - Fast PWM 11: set on match, clear at BOTTOM
// RQ8 - Fast PWM, compare equals TOP, upper bit set: ignore match, BOTTOM only
// RQ9 - Phase correct 10: clear on up match, set on down match
// RQ10 - Phase correct 11: set on up match, clear on down match
// RQ11 - Phase correct, compare equals TOP, upper bit set: act at TOP instead
// RQ12 - Software disables interrupts and reloads registers when switching clock source
// RQ13 - Async writes go via temporaries, landing after two async clock edges
// RQ14 - Software waits for busy flag before rewriting the same register
// RQ15 - Compare inhibited while count or compare write is pending
// RQ16 - Software waits for busy flag before sleeping when timer must wake
// RQ17 - Wake logic needs one full async cycle before another wake
// RQ18 - Wake starts on the timer clock following the interrupt condition
// RQ19 - Count reads come from a copy refreshed on each async edge
// RQ20 - Flags reach the processor after one timer cycle plus three cycles
// RQ21 - Compare pin changes on the timer step, not resynchronised
// RQ22 - Deep wake loses all timer register contents; code keeps the async select and the interrupt enables
// RQ23 - Async clock select switches the timer to the clock pin
// RQ24 - Busy flag set on async write, cleared when transfer completes
package timer_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int SLOTS = 5;
	localparam logic [2:0] REG_COUNT = 3'h0;
	localparam logic [2:0] REG_CMP_A = 3'h1;
	localparam logic [2:0] REG_CMP_B = 3'h2;
	localparam logic [2:0] REG_CTRL_A = 3'h3;
	localparam logic [2:0] REG_CTRL_B = 3'h4;
	localparam logic [2:0] REG_STATUS = 3'h5;
	localparam logic [2:0] REG_FLAGS = 3'h6;
	localparam logic [2:0] REG_IRQ_EN = 3'h7;
	localparam int CA_COM_A = 6;
	localparam int CA_COM_B = 4;
	localparam int CB_FORCE_A = 7;
	localparam int CB_FORCE_B = 6;
	localparam int CB_WGM2 = 3;
	localparam int CB_RUN = 0;
	localparam int ST_ASYNC = 5;
	localparam int ST_BUSY_LO = 0;
	localparam int FL_OVF = 0;
	localparam int FL_CMP_A = 1;
	localparam int FL_CMP_B = 2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] CTRL_B_MASK = 8'h3f;
	localparam logic [7:0] MAX_COUNT = 8'hff;
	localparam logic [7:0] BOTTOM = 8'h00;
	localparam int XFER_EDGES = 2;
	localparam int FLAG_SYNC_CYCLES = 3;
	localparam logic [2:0] WGM_CTC = 3'h2;
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	typedef enum logic [2:0] {
		WAVE_NONPWM = 3'b001,
		WAVE_FAST = 3'b010,
		WAVE_PHASE = 3'b100
	} wave_e;
endpackage

// >>> rtl/compare_output_unit.sv
// Purpose: One compare output channel: waveform state and pin enable
// Assumes: Match already gated by inhibit and write blocking
// Notes: State changes only on a timer step, a force or a loss of contents
`timescale 1ns/1ns
module compare_output_unit
	import timer_pkg::*;
#(
	parameter bit IS_CHANNEL_A = 1'b1
) (
	input wire logic clock, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic lose, // Contents lost after deep wake
	input wire logic tick, // Timer step
	input wire logic match, // Count equals compare value
	input wire logic force_strobe, // force_compare_strobe
	input wire logic [1:0] mode, // compare_output_mode
	input wire wave_e wave, // Waveform family
	input wire logic wgm_top, // waveform_mode_top_bit
	input wire logic count_up, // Counting direction
	input wire logic wrap, // Fast PWM step back to BOTTOM
	input wire logic at_top, // Phase correct turn at TOP
	input wire logic cmp_at_top, // Compare value equals TOP
	output logic state_reg, // compare_output_state
	output logic drive_reg // Pin enable
);
	function automatic logic apply(input logic [1:0] m, input logic s);
		case (m)
			COM_TOGGLE: apply = ~s;
			COM_CLEAR: apply = 1'b0;
			COM_SET: apply = 1'b1;
			default: apply = s;
		endcase
	endfunction

	logic toggle_ok, suppress, connected, state_next;
	logic [1:0] match_mode, edge_mode;

	assign toggle_ok = (wave == WAVE_NONPWM) || (IS_CHANNEL_A && wgm_top); // see RQ5
	assign suppress = (wave != WAVE_NONPWM) && cmp_at_top && mode[1]; // see RQ8 see RQ11
	// Edge action is the opposite of the match action of the same mode
	assign edge_mode = {1'b1, ~mode[0]};
	assign match_mode = (mode == COM_TOGGLE && !toggle_ok) ? COM_OFF :
		(wave == WAVE_PHASE && !count_up && mode[1]) ? edge_mode : mode; // see RQ9 see RQ10
	assign connected = (mode != COM_OFF) && !(mode == COM_TOGGLE && !toggle_ok); // see RQ4

	always_comb begin
		state_next = state_reg;
		if (lose) begin
			state_next = 1'b0; // see RQ22
		end else if (force_strobe && wave == WAVE_NONPWM) begin
			state_next = apply(mode, state_reg); // see RQ3
		end else if (tick) begin
			if (wave == WAVE_FAST && wrap && mode[1]) begin
				state_next = apply(edge_mode, state_next); // see RQ6 see RQ7
			end
			if (wave == WAVE_PHASE && at_top && suppress) begin
				state_next = apply(edge_mode, state_next); // see RQ11
			end
			// Mode is sampled at the match itself, so a rewrite acts from the next one
			if (match && !suppress) begin
				state_next = apply(match_mode, state_next); // see RQ1 see RQ2 see RQ4
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= 1'b0;
			drive_reg <= 1'b0;
		end else begin
			state_reg <= state_next; // see RQ21
			drive_reg <= connected;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	chk_off_holds: // see RQ1
	assert property ((mode == COM_OFF) && !lose |=> $stable(state_reg))
		else $error("state moved with mode off");
	chk_force_sets: // see RQ3
	assert property (force_strobe && wave == WAVE_NONPWM && mode == COM_SET && !lose |=> state_reg)
		else $error("force did not set output");
	chk_fast_bottom: // see RQ6
	assert property (tick && wave == WAVE_FAST && wrap && mode == COM_CLEAR && !match && !lose
		|=> state_reg) else $error("fast pwm bottom set missing");
	chk_fast_invert: // see RQ7
	assert property (tick && wave == WAVE_FAST && match && !suppress && mode == COM_SET && !lose
		|=> state_reg) else $error("inverting match did not set");
	chk_top_ignored: // see RQ8
	assert property (tick && wave == WAVE_FAST && match && suppress && !lose
		|=> state_reg == !$past(mode[0])) else $error("match at top not ignored");
	chk_phase_dir: // see RQ9
	assert property (tick && wave == WAVE_PHASE && match && !suppress && !at_top && !lose
		&& mode == COM_CLEAR |=> state_reg == !$past(count_up)) else $error("phase action wrong");
	chk_change_cause: // see RQ21
	assert property (!$stable(state_reg) |-> $past(tick) || $past(force_strobe) || $past(lose))
		else $error("output changed off a timer step");
endmodule // compare_output_unit

// >>> rtl/async_timer_compare_output.sv
// Purpose: 8-bit timer with two compare outputs and asynchronous clock pin operation
// Assumes: Clock pin is far slower than clock; sampled through two flip-flops
// Notes: Plain register port, read data one cycle after the read strobe
`timescale 1ns/1ns
module async_timer_compare_output
	import timer_pkg::*;
#(
	parameter int XFER_EDGE_COUNT = XFER_EDGES
) (
	input wire logic clock, // System clock, 20 MHz
	input wire logic rstn, // Async reset, active low
	input wire logic [ADDR_W-1:0] addr, // Register index
	input wire logic [DATA_W-1:0] wdata, // Write data
	input wire logic wr_strobe, // Write strobe
	input wire logic rd_strobe, // Read strobe
	output logic [DATA_W-1:0] rdata, // Read data, cycle after strobe
	input wire logic async_clock_pin, // Low-frequency clock pin
	input wire logic deep_wake, // Woke from power-down or standby
	output logic compare_pin_a, // Channel A output level
	output logic compare_pin_a_en, // Channel A pin enable
	output logic compare_pin_b, // Channel B output level
	output logic compare_pin_b_en, // Channel B pin enable
	output logic wake_req // Wake pulse from async timer
);
	initial begin
		if (XFER_EDGE_COUNT < 1 || XFER_EDGE_COUNT > 3) begin
			$error("XFER_EDGE_COUNT must be 1 to 3");
		end
	end

	localparam logic [1:0] LAST_EDGE = 2'(XFER_EDGE_COUNT - 1);

	function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] a);
		case (a)
			REG_COUNT: slot_of = 3'h0;
			REG_CMP_A: slot_of = 3'h1;
			REG_CMP_B: slot_of = 3'h2;
			REG_CTRL_A: slot_of = 3'h3;
			REG_CTRL_B: slot_of = 3'h4;
			default: slot_of = 3'h7;
		endcase
	endfunction

	function automatic wave_e wave_of(input logic [2:0] w);
		case (w[1:0])
			2'h1: wave_of = WAVE_PHASE;
			2'h3: wave_of = WAVE_FAST;
			default: wave_of = WAVE_NONPWM;
		endcase
	endfunction

	// Pin sampling
	logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
	// Registers and transfer slots
	logic [7:0] count_reg, view_reg, cmp_a_reg, cmp_b_reg, ctrl_a_reg, ctrl_b_reg;
	logic [7:0] tmp_reg [SLOTS];
	logic [1:0] edge_cnt_reg [SLOTS];
	logic [SLOTS-1:0] busy_reg;
	logic async_sel_reg, up_reg, block_reg;
	logic [2:0] irq_en_reg, flags_reg, hold_reg, sync1_reg, sync2_reg;
	logic wake_arm_reg, wake_block_reg, wake_req_reg;
	logic [7:0] rdata_reg;
	logic state_a, state_b, drive_a, drive_b;

	logic async_edge, tick, lose, wr_async, wr_direct, force_a, force_b;
	logic [2:0] wr_slot, wgm, ev_now, flags_next;
	logic [SLOTS-1:0] commit, load_en;
	logic [7:0] load_val [SLOTS];
	logic [7:0] top_val, count_next, status_val, read_mux;
	wave_e wave;
	logic match_a, match_b, inhibit_a, inhibit_b, ovf, wrap, at_top, wake_fire;

	assign async_edge = pin_sync_reg & ~pin_prev_reg;
	assign lose = deep_wake;
	// Timer steps on every clock while the CB_RUN bit is set, or on each rising edge of the pin when async
	assign tick = ctrl_b_reg[CB_RUN] & (async_sel_reg ? async_edge : 1'b1); // see RQ23
	assign wr_slot = slot_of(addr);
	assign wr_async = wr_strobe & async_sel_reg;
	assign wr_direct = wr_strobe & ~async_sel_reg;

	genvar gi;
	generate
		for (gi = 0; gi < SLOTS; gi++) begin : g_slot
			assign commit[gi] = busy_reg[gi] & async_edge & (edge_cnt_reg[gi] == LAST_EDGE);
			assign load_en[gi] = commit[gi] | (wr_direct & (wr_slot == 3'(gi))); // see RQ13
			assign load_val[gi] = commit[gi] ? tmp_reg[gi] : wdata;
		end
	endgenerate

	assign force_a = load_en[4] & load_val[4][CB_FORCE_A]; // see RQ3
	assign force_b = load_en[4] & load_val[4][CB_FORCE_B];

	assign wgm = {ctrl_b_reg[CB_WGM2], ctrl_a_reg[1:0]};
	assign wave = wave_of(wgm);
	assign top_val = (wgm == WGM_CTC || wgm[2]) ? cmp_a_reg : MAX_COUNT;
	assign wrap = (wave != WAVE_PHASE) && (count_reg == top_val);
	assign at_top = (wave == WAVE_PHASE) && up_reg && (count_reg == top_val);
	assign ovf = (wave == WAVE_PHASE) ? (count_reg == BOTTOM && !up_reg) : (count_reg == MAX_COUNT);
	// Pending writes of count or compare value hold the comparator off
	assign inhibit_a = busy_reg[0] | busy_reg[1] | block_reg; // see RQ15
	assign inhibit_b = busy_reg[0] | busy_reg[2] | block_reg; // see RQ15
	assign match_a = (count_reg == cmp_a_reg) & ~inhibit_a;
	assign match_b = (count_reg == cmp_b_reg) & ~inhibit_b;
	assign ev_now = tick ? {match_b, match_a, ovf} : 3'h0;

	always_comb begin
		count_next = count_reg + 8'h01;
		if (wave == WAVE_PHASE) begin
			if (up_reg ? (count_reg == top_val) : (count_reg != BOTTOM)) begin
				count_next = count_reg - 8'h01;
			end
		end else if (wrap) begin
			count_next = BOTTOM;
		end
	end

	assign status_val = {2'h0, async_sel_reg, busy_reg};
	assign read_mux = (addr == REG_COUNT) ? view_reg :
		(addr == REG_CMP_A) ? cmp_a_reg :
		(addr == REG_CMP_B) ? cmp_b_reg :
		(addr == REG_CTRL_A) ? ctrl_a_reg :
		(addr == REG_CTRL_B) ? ctrl_b_reg :
		(addr == REG_STATUS) ? status_val :
		(addr == REG_FLAGS) ? {5'h00, flags_reg} : {5'h00, irq_en_reg};

	// Set wins over a write-one clear
	assign flags_next = lose ? 3'h0 :
		(flags_reg & ~((wr_strobe && addr == REG_FLAGS) ? wdata[2:0] : 3'h0)) | sync2_reg;
	assign wake_fire = tick & wake_arm_reg & ~wake_block_reg; // see RQ18

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg <= async_clock_pin;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busy_reg <= '0;
			for (int i = 0; i < SLOTS; i++) begin
				tmp_reg[i] <= RST_BYTE;
				edge_cnt_reg[i] <= 2'h0;
			end
		end else begin
			for (int i = 0; i < SLOTS; i++) begin
				if (lose) begin
					busy_reg[i] <= 1'b0;
					edge_cnt_reg[i] <= 2'h0;
				end else if (wr_async && wr_slot == 3'(i)) begin
					tmp_reg[i] <= wdata; // see RQ13
					busy_reg[i] <= 1'b1; // see RQ24
					edge_cnt_reg[i] <= 2'h0;
				end else if (commit[i]) begin
					busy_reg[i] <= 1'b0; // see RQ24
				end else if (busy_reg[i] && async_edge) begin
					edge_cnt_reg[i] <= edge_cnt_reg[i] + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count_reg <= RST_BYTE;
			up_reg <= 1'b1;
			block_reg <= 1'b0;
		end else if (lose) begin
			count_reg <= RST_BYTE; // see RQ22
			up_reg <= 1'b1;
			block_reg <= 1'b0;
		end else begin
			if (load_en[0]) begin
				count_reg <= load_val[0];
			end else if (tick) begin
				count_reg <= count_next;
			end
			if (tick) begin
				up_reg <= (wave != WAVE_PHASE) | (up_reg ? (count_reg != top_val) : (count_reg == BOTTOM));
			end
			// A count load masks the match of the following timer step
			if (load_en[0]) begin
				block_reg <= 1'b1;
			end else if (tick) begin
				block_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cmp_a_reg <= RST_BYTE;
			cmp_b_reg <= RST_BYTE;
			ctrl_a_reg <= RST_BYTE;
			ctrl_b_reg <= RST_BYTE;
		end else if (lose) begin
			cmp_a_reg <= RST_BYTE;
			cmp_b_reg <= RST_BYTE;
			ctrl_a_reg <= RST_BYTE;
			ctrl_b_reg <= RST_BYTE;
		end else begin
			if (load_en[1]) cmp_a_reg <= load_val[1];
			if (load_en[2]) cmp_b_reg <= load_val[2];
			if (load_en[3]) ctrl_a_reg <= load_val[3];
			if (load_en[4]) ctrl_b_reg <= load_val[4] & CTRL_B_MASK;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			async_sel_reg <= 1'b0;
			irq_en_reg <= 3'h0;
			view_reg <= RST_BYTE;
			rdata_reg <= RST_BYTE;
		end else begin
			if (wr_strobe && addr == REG_STATUS) async_sel_reg <= wdata[ST_ASYNC]; // see RQ23
			if (wr_strobe && addr == REG_IRQ_EN) irq_en_reg <= wdata[2:0];
			// Read copy moves only on a pin edge when async, and a deep wake clears it to zero
			if (lose) begin
				view_reg <= RST_BYTE;
			end else if (async_sel_reg ? async_edge : 1'b1) begin
				view_reg <= count_reg; // see RQ19
			end
			rdata_reg <= rd_strobe ? read_mux : RST_BYTE;
		end
	end

	// Event waits one timer step in hold, then crosses three system cycles
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hold_reg <= 3'h0;
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			flags_reg <= 3'h0;
		end else begin
			if (tick) hold_reg <= ev_now;
			sync1_reg <= tick ? hold_reg : 3'h0; // see RQ20
			sync2_reg <= sync1_reg;
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wake_arm_reg <= 1'b0;
			wake_block_reg <= 1'b0;
			wake_req_reg <= 1'b0;
		end else begin
			if (|(ev_now & irq_en_reg) && async_sel_reg) begin
				wake_arm_reg <= 1'b1;
			end else if (wake_fire) begin
				wake_arm_reg <= 1'b0;
			end
			// One full pin cycle must pass before the next wake
			if (wake_fire) begin
				wake_block_reg <= 1'b1; // see RQ17
			end else if (tick) begin
				wake_block_reg <= 1'b0;
			end
			wake_req_reg <= wake_fire;
		end
	end

	compare_output_unit #(
		.IS_CHANNEL_A(1'b1)
	) u_chan_a (
		.clock(clock),
		.rstn(rstn),
		.lose(lose),
		.tick(tick),
		.match(match_a),
		.force_strobe(force_a),
		.mode(ctrl_a_reg[CA_COM_A+1:CA_COM_A]),
		.wave(wave),
		.wgm_top(ctrl_b_reg[CB_WGM2]),
		.count_up(up_reg),
		.wrap(wrap),
		.at_top(at_top),
		.cmp_at_top(cmp_a_reg == top_val),
		.state_reg(state_a),
		.drive_reg(drive_a)
	);

	compare_output_unit #(
		.IS_CHANNEL_A(1'b0)
	) u_chan_b (
		.clock(clock),
		.rstn(rstn),
		.lose(lose),
		.tick(tick),
		.match(match_b),
		.force_strobe(force_b),
		.mode(ctrl_a_reg[CA_COM_B+1:CA_COM_B]),
		.wave(wave),
		.wgm_top(ctrl_b_reg[CB_WGM2]),
		.count_up(up_reg),
		.wrap(wrap),
		.at_top(at_top),
		.cmp_at_top(cmp_b_reg == top_val),
		.state_reg(state_b),
		.drive_reg(drive_b)
	);

	// Pin follows the channel flop directly, on the timer step
	assign compare_pin_a = state_a; // see RQ21
	assign compare_pin_a_en = drive_a;
	assign compare_pin_b = state_b;
	assign compare_pin_b_en = drive_b;
	assign rdata = rdata_reg;
	assign wake_req = wake_req_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	chk_busy_set: // see RQ24
	assert property (wr_async && addr == REG_CTRL_A && !lose |=> busy_reg[3])
		else $error("busy flag not set on async write");
	chk_commit_edge: // see RQ13
	assert property ($fell(busy_reg[1]) && !$past(lose) |-> $past(async_edge))
		else $error("transfer landed off a pin edge");
	chk_commit_value: // see RQ13
	assert property (commit[2] && !lose |=> cmp_b_reg == $past(tmp_reg[2]))
		else $error("temporary value not transferred");
	chk_cmp_inhibit: // see RQ15
	assert property (busy_reg[1] || busy_reg[0] |-> !match_a)
		else $error("compare active during pending write");
	chk_flag_latency: // see RQ20
	assert property (tick && hold_reg[FL_CMP_A] |-> ##3 flags_reg[FL_CMP_A])
		else $error("flag crossing latency wrong");
	chk_wake_block: // see RQ17
	assert property (wake_block_reg && !tick |=> wake_block_reg)
		else $error("wake repeated inside one pin cycle");
	chk_wake_step: // see RQ18
	assert property (wake_req_reg |-> $past(tick))
		else $error("wake not on a timer step");
	chk_view_hold: // see RQ19
	assert property (async_sel_reg && !async_edge && !lose |=> $stable(view_reg))
		else $error("count copy moved without pin edge");
endmodule // async_timer_compare_output

// >>> testbench/test_async_timer_compare_output.sv
// Purpose: Self-checking bench for the async timer compare-output block
// Assumes: Register map and timing of the block; pin edges made by the bench
// Notes: PWM duty is measured over one full period, so output latency cancels out
`timescale 1ns/1ns
module test_async_timer_compare_output
	import timer_pkg::*;
;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr_strobe = 1'b0;
	logic rd_strobe = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic async_clock_pin = 1'b0;
	logic deep_wake = 1'b0;
	logic compare_pin_a, compare_pin_a_en, compare_pin_b, compare_pin_b_en, wake_req;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	int n_wake = 0;
	logic [31:0] seed = 32'hb87a;
	logic [7:0] rv, cv, got, st;
	int h, per, expd;
	logic [1:0] force_modes [6] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h2, 2'h3};

	always #25 clock = ~clock;

	async_timer_compare_output #(.XFER_EDGE_COUNT(XFER_EDGES)) DUT (.clock(clock), .rstn(rstn),
		.addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
		.async_clock_pin(async_clock_pin), .deep_wake(deep_wake),
		.compare_pin_a(compare_pin_a), .compare_pin_a_en(compare_pin_a_en),
		.compare_pin_b(compare_pin_b), .compare_pin_b_en(compare_pin_b_en), .wake_req(wake_req));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected high steps per period for a PWM channel A setup
	function automatic int pwm_high(input logic fast, input logic [1:0] m, input logic [7:0] c);
		int hi;
		hi = fast ? ((c == MAX_COUNT) ? 256 : c + 1) : 2 * c;
		return (m == COM_SET) ? (fast ? 256 : 510) - hi : hi;
	endfunction

	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_strobe <= 1'b1;
		@(posedge clock);
		wr_strobe <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clock);
		rd_strobe <= 1'b0;
		#5 d = rdata;
	endtask

	// Slow pin: ten system clocks high, ten low, well below a quarter of the rate
	task automatic pin_edges(input int n);
		repeat (n) begin
			repeat (10) @(posedge clock);
			async_clock_pin <= 1'b1;
			repeat (10) @(posedge clock);
			async_clock_pin <= 1'b0;
		end
		repeat (8) @(posedge clock);
	endtask

	// Wake pulses counted on the falling clock edge, away from the rising edge that launches them
	always @(negedge clock) begin
		if (wake_req === 1'b1) begin
			n_wake <= n_wake + 1;
		end
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		#5 check({wake_req, compare_pin_a, compare_pin_a_en, compare_pin_b, compare_pin_b_en}, 8'h00);
		rd(REG_STATUS, got);
		check(got, 8'h00);
		// Force strobe in normal mode with the counter stopped
		st = 8'h00;
		foreach (force_modes[i]) begin
			wr(REG_CTRL_A, {force_modes[i], force_modes[i], 4'h0});
			wr(REG_CTRL_B, 8'hc0);
			repeat (3) @(posedge clock);
			case (force_modes[i])
				COM_TOGGLE: st[0] = ~st[0];
				COM_CLEAR: st[0] = 1'b0;
				COM_SET: st[0] = 1'b1;
				default: st[0] = st[0];
			endcase
			#5 check({4'h0, compare_pin_a, compare_pin_a_en, compare_pin_b, compare_pin_b_en},
				{4'h0, st[0], force_modes[i] != 0, st[0], force_modes[i] != 0});
		end
		// PWM mode 01 without the top mode bit leaves channel A disconnected
		wr(REG_CTRL_A, 8'h43);
		wr(REG_CTRL_B, 8'h00);
		repeat (3) @(posedge clock);
		#5 check({7'h00, compare_pin_a_en}, 8'h00);
		// Duty of fast and phase correct PWM, random compare values plus the TOP case
		for (int k = 0; k < 6; k++) begin
			seed = lfsr_next(seed);
			cv = (k % 3 == 2) ? MAX_COUNT : 8'h10 + (seed[7:0] % 8'hd0);
			wr(REG_CMP_A, cv);
			wr(REG_CTRL_A, {(k % 3 == 1) ? COM_SET : COM_CLEAR, 4'h0, (k < 3) ? 2'h3 : 2'h1});
			wr(REG_CTRL_B, 8'h01);
			repeat (520) @(posedge clock);
			per = (k < 3) ? 256 : 510;
			expd = pwm_high(k < 3, (k % 3 == 1) ? COM_SET : COM_CLEAR, cv);
			h = 0;
			repeat (per) begin
				@(posedge clock);
				#5 h += (compare_pin_a === 1'b1);
			end
			check({7'h00, (h >= expd - 2) && (h <= expd + 2)}, 8'h01);
			wr(REG_CTRL_B, 8'h00);
		end
		// Asynchronous writes wait in their own temporaries for two pin edges
		wr(REG_STATUS, 8'h20);
		seed = lfsr_next(seed);
		rv = seed[7:0];
		seed = lfsr_next(seed);
		cv = seed[15:8];
		wr(REG_COUNT, rv);
		wr(REG_CMP_A, cv);
		rd(REG_STATUS, got);
		check(got, 8'h23);
		pin_edges(1);
		rd(REG_STATUS, got);
		check(got, 8'h23);
		pin_edges(1);
		rd(REG_STATUS, got);
		check(got, 8'h20);
		// Read copy follows the count only at the next pin edge
		pin_edges(1);
		rd(REG_COUNT, got);
		check(got, rv);
		rd(REG_CMP_A, got);
		check(got, cv);
		// Enabled overflow arms one wake, given on the step after the event
		wr(REG_IRQ_EN, 8'h01);
		wr(REG_CTRL_A, 8'h00);
		wr(REG_COUNT, MAX_COUNT);
		wr(REG_CTRL_B, 8'h01);
		pin_edges(2);
		rd(REG_STATUS, got);
		check(got, 8'h20);
		check(8'(n_wake), 8'h00);
		pin_edges(2);
		check(8'(n_wake), 8'h01);
		rd(REG_FLAGS, got);
		check(got & 8'h01, 8'h01);
		wr(REG_FLAGS, 8'h07);
		rd(REG_FLAGS, got);
		check(got, 8'h00);
		// Loss of contents after a deep wake keeps only the source select and the interrupt enables
		wr(REG_CTRL_B, 8'h00);
		pin_edges(2);
		rd(REG_STATUS, got);
		check(got, 8'h20);
		deep_wake <= 1'b1;
		repeat (2) @(posedge clock);
		deep_wake <= 1'b0;
		rd(REG_CMP_A, got);
		check(got, 8'h00);
		rd(REG_STATUS, got);
		check(got, 8'h20);
		#5 check({7'h00, compare_pin_a}, 8'h00);
		test_done();
	end
endmodule // test_async_timer_compare_output
